/* logic/rsrc_cfg.svh */
// timing counts, field positions and vector addresses of the reset and recovery controller
`ifndef RSRC_CFG_SVH
`define RSRC_CFG_SVH
`define RSRC_CLK_HZ 10000000
`define RSRC_OSC_CYC_SHORT 66
`define RSRC_OSC_CYC_XTAL 5000
`define RSRC_PIN_QUAL 4
`define RSRC_ADDR_STATUS 8'h00
`define RSRC_ADDR_CTRL 8'h04
`define RSRC_ADDR_OSC 8'h08
`define RSRC_BIT_POR 7
`define RSRC_BIT_STOP 6
`define RSRC_BIT_WDT 5
`define RSRC_BIT_EXT 4
`define RSRC_BIT_LVD 0
`define RSRC_VECTOR_HI 16'h0002
`define RSRC_VECTOR_LO 16'h0003
`endif

/* logic/rsrc_pkg.sv */
// types of the reset and recovery controller
package rsrc_pkg;
    typedef enum {
        RSRC_RUN,
        RSRC_HOLD,
        RSRC_COUNT,
        RSRC_PINWAIT
    } rsrc_state_t;
    typedef struct packed {
        logic por;
        logic stop;
        logic wdt;
        logic external_reset_flag;
    } rsrc_cause_t;
    typedef struct packed {
        logic xtal_enable;
        logic watchdog_reset_select;
        logic brown_out_in_stop;
    } rsrc_option_t;
endpackage

/* logic/rsrc_ctrl.sv */
// reset and stop mode recovery controller with wishbone status port
`timescale 1ns/1ps
`include "rsrc_cfg.svh"
module rsrc_ctrl
    import rsrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_tick_i,
    input wire logic power_good_i,
    input wire logic brown_out_detect_i,
    input wire logic low_voltage_i,
    input wire logic watchdog_timeout_i,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    input wire logic debug_pin_i,
    input wire logic stop_mode_i,
    input wire rsrc_option_t option_i,
    input wire logic [7:0] port_pins_i,
    input wire logic [7:0] recovery_enable_i,
    output logic [7:0] port_input_data_o,
    output logic cpu_reset_o,
    output logic system_reset_o,
    output logic watchdog_irq_o,
    output logic osc_reinit_o,
    output logic [15:0] vector_addr_o,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o
);
    // --------------------------------------------------------------
    // pin qualifier
    // --------------------------------------------------------------
    logic pin_s1;
    logic pin_s2;
    logic [2:0] low_cnt;
    wire pin_low = !pin_s2;
    wire pin_qualified = (low_cnt == 3'(`RSRC_PIN_QUAL - 1)) && pin_low;
    always_ff @(posedge clk_i) begin
        pin_s1 <= reset_pin_i;
        pin_s2 <= pin_s1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !pin_low) begin
            low_cnt <= 3'h0;
        end else if (low_cnt != 3'(`RSRC_PIN_QUAL)) begin
            low_cnt <= low_cnt + 3'h1;
        end
    end
    // the 2-flop synchroniser adds latency only; a short low never reaches the count
    wire pin_event = pin_low && (low_cnt >= 3'(`RSRC_PIN_QUAL - 1));

    // --------------------------------------------------------------
    // event classification
    // --------------------------------------------------------------
    logic debug_reset_req;
    logic [7:0] pin_prev;
    wire bo_active = brown_out_detect_i && (!stop_mode_i || option_i.brown_out_in_stop);
    wire power_bad = !power_good_i || bo_active;
    wire wdt_sys = watchdog_timeout_i && !stop_mode_i && option_i.watchdog_reset_select;
    wire wdt_smr = watchdog_timeout_i && stop_mode_i;
    wire pin_change = stop_mode_i && |((port_pins_i ^ pin_prev) & recovery_enable_i);
    wire dbg_pin_rst = stop_mode_i && !debug_pin_i;
    wire sys_event = pin_event || wdt_sys || debug_reset_req || dbg_pin_rst;
    wire smr_event = wdt_smr || pin_change;

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    rsrc_state_t state;
    logic in_smr;
    logic [12:0] osc_cnt;
    wire [12:0] delay_len = option_i.xtal_enable ? 13'(`RSRC_OSC_CYC_XTAL) :
        13'(`RSRC_OSC_CYC_SHORT);
    wire count_done = osc_tick_i && (osc_cnt == delay_len - 13'h1);
    rsrc_cause_t cause;
    logic read_clear;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RSRC_HOLD;
            in_smr <= 1'b0;
            osc_cnt <= 13'h0;
        end else begin
            case (state)
                RSRC_RUN: begin
                    osc_cnt <= 13'h0;
                    if (power_bad) begin
                        state <= RSRC_HOLD;
                        in_smr <= 1'b0;
                    end else if (sys_event) begin
                        state <= RSRC_COUNT;
                        in_smr <= 1'b0;
                    end else if (smr_event) begin
                        state <= RSRC_COUNT;
                        in_smr <= 1'b1;
                    end
                end
                RSRC_HOLD: begin
                    osc_cnt <= 13'h0;
                    if (!power_bad) begin
                        state <= RSRC_COUNT;
                    end
                end
                RSRC_COUNT: begin
                    if (power_bad) begin
                        state <= RSRC_HOLD;
                        in_smr <= 1'b0;
                    end else if (count_done) begin
                        state <= (pin_low && !in_smr) ? RSRC_PINWAIT : RSRC_RUN;
                    end else if (osc_tick_i) begin
                        osc_cnt <= osc_cnt + 13'h1;
                    end
                end
                RSRC_PINWAIT: begin
                    if (power_bad) begin
                        state <= RSRC_HOLD;
                    end else if (!pin_low) begin
                        state <= RSRC_RUN;
                    end
                end
                default: state <= RSRC_HOLD;
            endcase
        end
    end

    wire in_reset = (state != RSRC_RUN);
    wire sys_reset = in_reset && !in_smr;
    assign cpu_reset_o = in_reset;
    assign system_reset_o = sys_reset;
    // open drain: drive low during hold and the system reset count, not during recovery or the pin wait
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = (state == RSRC_HOLD) || (state == RSRC_COUNT && !in_smr);
    assign osc_reinit_o = in_reset;
    assign vector_addr_o = in_reset ? `RSRC_VECTOR_HI : `RSRC_VECTOR_LO;
    assign watchdog_irq_o = watchdog_timeout_i && !option_i.watchdog_reset_select;

    // bus decode needed by the control write, declared ahead of its first use
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit_ctrl = (wb_adr_i == `RSRC_ADDR_CTRL);
    wire wb_write_ctrl = wb_req && wb_we_i && hit_ctrl;

    // debug request self-clears once the system reset begins
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_reset) begin
            debug_reset_req <= 1'b0;
        end else if (wb_write_ctrl && wb_sel_i[0]) begin
            debug_reset_req <= wb_dat_i[0];
        end
    end

    // port input data freezes in stop; sampled again only after recovery ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev <= 8'h00;
            port_input_data_o <= 8'h00;
        end else begin
            if (!stop_mode_i || state == RSRC_RUN && !stop_mode_i) begin
                pin_prev <= port_pins_i;
            end
            if (!stop_mode_i && !in_reset) begin
                port_input_data_o <= port_pins_i;
            end
        end
    end

    // --------------------------------------------------------------
    // cause flags
    // --------------------------------------------------------------
    logic ev_por;
    logic ev_ext;
    logic ev_wdt;
    logic ev_stop;
    logic ev_pinsmr;
    assign ev_por = (state == RSRC_HOLD) || (state == RSRC_RUN && !power_bad &&
        (debug_reset_req || dbg_pin_rst) && !pin_event);
    assign ev_ext = state == RSRC_RUN && !power_bad && pin_event;
    assign ev_wdt = state == RSRC_RUN && !power_bad && !sys_event && wdt_smr ||
        state == RSRC_RUN && !power_bad && wdt_sys && !pin_event;
    assign ev_stop = state == RSRC_RUN && !power_bad && !sys_event && smr_event;
    assign ev_pinsmr = ev_stop && !wdt_smr;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b0};
        end else if (ev_por) begin
            cause <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b0};
        end else if (ev_ext) begin
            cause <= '{por: 1'b0, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b1};
        end else if (ev_wdt) begin
            cause <= '{por: 1'b0, stop: ev_stop, wdt: 1'b1, external_reset_flag: 1'b0};
        end else if (ev_pinsmr) begin
            cause <= '{por: 1'b0, stop: 1'b1, wdt: 1'b0, external_reset_flag: 1'b0};
        end else if (read_clear) begin
            cause <= '{por: 1'b0, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b0};
        end
    end

    // --------------------------------------------------------------
    // wishbone slave, one wait state ack
    // --------------------------------------------------------------
    wire hit_status = (wb_adr_i == `RSRC_ADDR_STATUS);
    wire hit_osc = (wb_adr_i == `RSRC_ADDR_OSC);
    wire [31:0] status_word = {24'h0, cause.por, cause.stop, cause.wdt, cause.external_reset_flag, 3'h0,
        low_voltage_i};
    wire [31:0] read_mux = hit_status ? status_word :
        hit_ctrl ? {31'h0, debug_reset_req} :
        hit_osc ? {31'h0, osc_reinit_o} : 32'h0;
    assign read_clear = wb_req && !wb_we_i && hit_status && wb_sel_i[0] && !in_reset;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? read_mux : 32'h0;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_short_pin_ignored;
        @(posedge clk_i) disable iff (rst_i)
        ev_ext |-> (pin_low && $past(pin_low) && $past(pin_low, 2));
    endproperty
    a_short_pin_ignored: assert property (p_short_pin_ignored) else $error("short pulse reset");
    property p_pin_starts;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && pin_qualified && !power_bad) |=> (state == RSRC_COUNT && cause.external_reset_flag);
    endproperty
    a_pin_starts: assert property (p_pin_starts) else $error("pin reset not started");
    property p_pinwait;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_PINWAIT && pin_low && !power_bad) |=> cpu_reset_o;
    endproperty
    a_pinwait: assert property (p_pinwait) else $error("left reset with pin low");
    property p_brownout;
        @(posedge clk_i) disable iff (rst_i)
        power_bad |=> (state == RSRC_HOLD && reset_pin_oe_o);
    endproperty
    a_brownout: assert property (p_brownout) else $error("no hold on brown out");
    property p_smr_flag;
        @(posedge clk_i) disable iff (rst_i)
        ev_stop |=> (cause.stop && in_smr && cpu_reset_o && !reset_pin_oe_o);
    endproperty
    a_smr_flag: assert property (p_smr_flag) else $error("recovery flag missing");
    property p_read_clear;
        @(posedge clk_i) disable iff (rst_i)
        (read_clear && !ev_por && !ev_ext && !ev_wdt && !ev_stop) |=> (cause == 4'h0);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");
    property p_dbg_clear;
        @(posedge clk_i) disable iff (rst_i)
        (debug_reset_req && state == RSRC_COUNT) |=> !debug_reset_req;
    endproperty
    a_dbg_clear: assert property (p_dbg_clear) else $error("debug request stuck");
    property p_wdt_int_only;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && watchdog_timeout_i && !stop_mode_i &&
            !option_i.watchdog_reset_select && !power_bad && !pin_event &&
            !debug_reset_req) |=> !cpu_reset_o;
    endproperty
    a_wdt_int_only: assert property (p_wdt_int_only) else $error("watchdog reset wrongly");

    // --------------------------------------------------------------
    // independent tick count for the hold length check
    // --------------------------------------------------------------
    // kept apart from osc_cnt so a broken counter cannot vouch for itself
    logic [12:0] tick_seen;
    always_ff @(posedge clk_i) begin
        if (rst_i || state != RSRC_COUNT) begin
            tick_seen <= 13'h0;
        end else if (osc_tick_i) begin
            tick_seen <= tick_seen + 13'h1;
        end
    end

    property p_count_length;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_COUNT && count_done && !power_bad) |->
            (tick_seen == (option_i.xtal_enable ? 13'(`RSRC_OSC_CYC_XTAL - 1) :
            13'(`RSRC_OSC_CYC_SHORT - 1)));
    endproperty
    a_count_length: assert property (p_count_length) else $error("hold length wrong");

    // in stop the pin still gives a full reset, never a recovery
    property p_stop_pin_sys;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && stop_mode_i && pin_event && !power_bad) |=>
            (state == RSRC_COUNT && system_reset_o);
    endproperty
    a_stop_pin_sys: assert property (p_stop_pin_sys) else $error("stop pin no reset");

    property p_dbg_pin_sys;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && stop_mode_i && !debug_pin_i && !power_bad) |=>
            (system_reset_o && cause.por);
    endproperty
    a_dbg_pin_sys: assert property (p_dbg_pin_sys) else $error("debug pin no reset");

    property p_wdt_smr;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && watchdog_timeout_i && stop_mode_i && !power_bad &&
            !sys_event) |=> (cause.wdt && cause.stop && in_smr);
    endproperty
    a_wdt_smr: assert property (p_wdt_smr) else $error("watchdog wake flags");

    // only enabled pins may wake; the compare is written out, not reused
    property p_pin_smr;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && stop_mode_i && !power_bad && !sys_event &&
            ((port_pins_i ^ pin_prev) & recovery_enable_i) != 8'h00) |=>
            (state == RSRC_COUNT && in_smr);
    endproperty
    a_pin_smr: assert property (p_pin_smr) else $error("pin change no wake");

    property p_frozen;
        @(posedge clk_i) disable iff (rst_i)
        (stop_mode_i || in_reset) |=> $stable(port_input_data_o);
    endproperty
    a_frozen: assert property (p_frozen) else $error("port data moved in stop");

    property p_pinwait_exit;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_PINWAIT && !pin_low && !power_bad) |=> !cpu_reset_o;
    endproperty
    a_pinwait_exit: assert property (p_pinwait_exit) else $error("late pin release");

    // with the option bit clear, brown-out is blind while stopped
    property p_bo_stop;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_RUN && stop_mode_i && !option_i.brown_out_in_stop && power_good_i &&
            !sys_event && !smr_event) |=> !cpu_reset_o;
    endproperty
    a_bo_stop: assert property (p_bo_stop) else $error("brown-out in stop acted");

    property p_por_flag;
        @(posedge clk_i) disable iff (rst_i)
        (state == RSRC_HOLD) |=> cause.por;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power-on flag missing");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

    c_pin_reset: cover property (@(posedge clk_i) disable iff (rst_i) ev_ext);
    c_wdt_wake: cover property (@(posedge clk_i) disable iff (rst_i) ev_wdt && ev_stop);
    c_smr: cover property (@(posedge clk_i) disable iff (rst_i) ev_stop);
    c_pinwait: cover property (@(posedge clk_i) disable iff (rst_i) state == RSRC_PINWAIT);
endmodule

/* tb/rsrc_board.sv */
// board side of the shared reset line: pull-up resistor and a push button
`timescale 1ns/1ps
module rsrc_board (
    input wire logic dev_oe_i,
    input wire logic dev_drive_i,
    input wire logic button_low_i,
    output logic pin_o
);
    // open-drain wire: any party pulling low wins, otherwise the pull-up holds it high
    assign pin_o = !((dev_oe_i && !dev_drive_i) || button_low_i);
endmodule

/* tb/tb_rsrc_ctrl.sv */
// self-checking bench for the reset and stop recovery controller
`timescale 1ns/1ps
module tb_rsrc_ctrl
    import rsrc_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, osc_tick_i = 1'b0, power_good_i = 1'b1;
    logic brown_out_detect_i = 1'b0, low_voltage_i = 1'b0, watchdog_timeout_i = 1'b0;
    logic button_low = 1'b0, debug_pin_i = 1'b1, stop_mode_i = 1'b0;
    rsrc_option_t option_i = 3'b010;
    logic [7:0] port_pins_i = 8'h00, recovery_enable_i = 8'h01, wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, q;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hF;
    wire logic reset_pin_i, reset_pin_o, reset_pin_oe_o, cpu_reset_o, system_reset_o;
    wire logic watchdog_irq_o, osc_reinit_o, wb_ack_o;
    wire logic [7:0] port_input_data_o;
    wire logic [15:0] vector_addr_o;
    wire logic [31:0] wb_dat_o;
    int error_cnt = 0, check_count = 0, x;

    rsrc_board u_rsrc_board (.dev_oe_i(reset_pin_oe_o), .dev_drive_i(reset_pin_o),
        .button_low_i(button_low), .pin_o(reset_pin_i));
    rsrc_ctrl u_rsrc_ctrl (.clk_i, .rst_i, .osc_tick_i, .power_good_i, .brown_out_detect_i,
        .low_voltage_i, .watchdog_timeout_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o,
        .debug_pin_i, .stop_mode_i, .option_i, .port_pins_i, .recovery_enable_i,
        .port_input_data_o, .cpu_reset_o, .system_reset_o, .watchdog_irq_o, .osc_reinit_o,
        .vector_addr_o, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
        .wb_stb_i, .wb_ack_o);

    initial begin
        forever #50 clk_i = !clk_i;
    end
    // oscillator ticks arrive every second clock, so counts take twice as many clocks
    always @(posedge clk_i) begin
        osc_tick_i <= !osc_tick_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        chk("bus ack", 32'(wb_ack_o), 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // waits out the hold, then checks its length, the vector and the cause flags
    task automatic finish_rst(input int ticks, input logic [31:0] st);
        int n;
        n = 0;
        while (cpu_reset_o !== 1'b0 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        chk("hold length", 32'(n >= 2 * ticks - 8 && n <= 2 * ticks + 16), 32'h1);
        chk("vector", 32'(vector_addr_o), 32'h3);
        wb_xfer(8'h00, 1'b0, 32'h0);
        chk("status", q, st);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        cyc(6);
        rst_i <= 1'b0;
        cyc(1);
        chk("pin drive", 32'(reset_pin_oe_o), 32'h1);
        chk("pin level", 32'(reset_pin_o), 32'h0);
        chk("vector", 32'(vector_addr_o), 32'h2);
        finish_rst(66, 32'h80);
        wb_xfer(8'h00, 1'b0, 32'h0);
        chk("status", q, 32'h0);
        wb_xfer(8'h0C, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        button_low <= 1'b1;
        cyc(2);
        button_low <= 1'b0;
        cyc(10);
        chk("glitch", 32'(cpu_reset_o), 32'h0);
        button_low <= 1'b1;
        cyc(4);
        button_low <= 1'b0;
        cyc(8);
        chk("pin reset", 32'(cpu_reset_o), 32'h1);
        chk("pin drive", 32'(reset_pin_oe_o), 32'h1);
        finish_rst(66, 32'h10);
        button_low <= 1'b1;
        cyc(400);
        chk("held", 32'(cpu_reset_o), 32'h1);
        button_low <= 1'b0;
        cyc(5);
        chk("held release", 32'(cpu_reset_o), 32'h0);
        wb_xfer(8'h00, 1'b0, 32'h0);
        watchdog_timeout_i <= 1'b1;
        cyc(1);
        watchdog_timeout_i <= 1'b0;
        cyc(2);
        chk("wdt reset", 32'(system_reset_o), 32'h1);
        finish_rst(66, 32'h20);
        option_i.watchdog_reset_select <= 1'b0;
        watchdog_timeout_i <= 1'b1;
        @(negedge clk_i);
        chk("wdt irq", 32'(watchdog_irq_o), 32'h1);
        @(posedge clk_i);
        watchdog_timeout_i <= 1'b0;
        cyc(4);
        chk("wdt no reset", 32'(cpu_reset_o), 32'h0);
        wb_xfer(8'h04, 1'b1, 32'h1);
        cyc(3);
        chk("debug reset", 32'(cpu_reset_o), 32'h1);
        finish_rst(66, 32'h80);
        wb_xfer(8'h04, 1'b0, 32'h0);
        chk("debug bit", q, 32'h0);
        for (x = 1; x >= 0; x--) begin
            option_i.xtal_enable <= x[0];
            stop_mode_i <= 1'b1;
            cyc(3);
            port_pins_i[1] <= !port_pins_i[1];
            cyc(6);
            chk("masked pin", 32'(cpu_reset_o), 32'h0);
            port_pins_i[0] <= !port_pins_i[0];
            cyc(3);
            chk("pin wake", 32'(cpu_reset_o), 32'h1);
            chk("recovery kind", 32'(system_reset_o), 32'h0);
            chk("osc restart", 32'(osc_reinit_o), 32'h1);
            chk("port frozen", 32'(port_input_data_o), 32'(port_pins_i ^ 8'h03));
            stop_mode_i <= 1'b0;
            finish_rst(x ? 5000 : 66, 32'h40);
        end
        stop_mode_i <= 1'b1;
        watchdog_timeout_i <= 1'b1;
        cyc(1);
        watchdog_timeout_i <= 1'b0;
        cyc(3);
        chk("wdt wake", 32'(cpu_reset_o & !system_reset_o), 32'h1);
        stop_mode_i <= 1'b0;
        finish_rst(66, 32'h60);
        stop_mode_i <= 1'b1;
        debug_pin_i <= 1'b0;
        cyc(4);
        chk("debug pin", 32'(system_reset_o), 32'h1);
        debug_pin_i <= 1'b1;
        stop_mode_i <= 1'b0;
        finish_rst(66, 32'h80);
        stop_mode_i <= 1'b1;
        brown_out_detect_i <= 1'b1;
        cyc(4);
        chk("brown-out in stop", 32'(cpu_reset_o), 32'h0);
        stop_mode_i <= 1'b0;
        low_voltage_i <= 1'b1;
        cyc(300);
        chk("brown-out hold", 32'(cpu_reset_o), 32'h1);
        brown_out_detect_i <= 1'b0;
        finish_rst(66, 32'h81);
        stop_test();
    end

    initial begin
        cyc(30000);
        error_cnt++;
        stop_test();
    end
endmodule
